// ---- verilog/tsr_defs.svh ----
// register offsets, field positions, reset values and timing counts of the sensor readout
`ifndef TSR_DEFS_SVH
`define TSR_DEFS_SVH

`define TSR_REG_LOCAL_MAIN   8'h00
`define TSR_REG_REMOTE_MAIN  8'h01
`define TSR_REG_STATUS       8'h02
`define TSR_REG_CFG_RD       8'h03
`define TSR_REG_RATE_RD      8'h04
`define TSR_REG_CFG_WR       8'h09
`define TSR_REG_RATE_WR      8'h0A
`define TSR_REG_ONE_SHOT     8'h0F
`define TSR_REG_REMOTE_FRAC  8'h10
`define TSR_REG_LOCAL_FRAC   8'h11

`define TSR_CFG_HALT_BIT     6
`define TSR_STATUS_BUSY_BIT  7

`define TSR_CFG_RESET        8'h20
`define TSR_RATE_RESET       8'h08
`define TSR_RATE_FASTEST     8'h08
`define TSR_RATE_EXT_MAX     8'h06
`define TSR_TEMP_RESET       8'h00
`define TSR_UNMAPPED_READ    8'h00

// slave address value is arbitrary
`define TSR_SLAVE_ADDR       7'h4C

`define TSR_CORE_CLK_NS      4
`define TSR_CONV_PERIOD_NS   62500000
`define TSR_CONV_CYCLES      (`TSR_CONV_PERIOD_NS / `TSR_CORE_CLK_NS)

`endif

// ---- verilog/tsr_pkg.sv ----
// shared types of the sensor readout
package tsr_pkg;

  typedef enum logic [2:0] {
    TSR_OP_SEL = 3'h1,
    TSR_OP_WR  = 3'h2,
    TSR_OP_RD  = 3'h4
  } tsr_op_type;

  typedef enum logic [1:0] {
    TSR_CONV_IDLE = 2'h1,
    TSR_CONV_RUN  = 2'h2
  } tsr_conv_state_type;

  typedef enum logic [4:0] {
    TSR_SER_IDLE    = 5'h01,
    TSR_SER_RECV    = 5'h02,
    TSR_SER_ACK_OUT = 5'h04,
    TSR_SER_SEND    = 5'h08,
    TSR_SER_ACK_IN  = 5'h10
  } tsr_ser_state_type;

  typedef enum logic [2:0] {
    TSR_PH_ADDR = 3'h1,
    TSR_PH_CMD  = 3'h2,
    TSR_PH_DATA = 3'h4
  } tsr_phase_type;

endpackage : tsr_pkg

// ---- verilog/tsr_link_if.sv ----
// register request channel between the serial engine and the core register file
interface tsr_link_if;
  logic               req_tgl;
  tsr_pkg::tsr_op_type op;
  logic [7:0]         addr;
  logic [7:0]         wdata;
  logic               ack_tgl;
  logic [7:0]         rdata;

  modport serial (output req_tgl, output op, output addr, output wdata, input ack_tgl, input rdata);
  modport core   (input req_tgl, input op, input addr, input wdata, output ack_tgl, output rdata);
endinterface : tsr_link_if

// ---- verilog/tsr_sync.sv ----
// two-flop level synchroniser
module tsr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } tsr_sync_state_type;

  tsr_sync_state_type r;
  tsr_sync_state_type next_r;

  always_comb begin
    next_r.stage1 = d_i;
    next_r.stage2 = r.stage1;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q_o = r.stage2;
endmodule : tsr_sync

// ---- verilog/tsr_smb_slave.sv ----
// serial slave engine on the link clock: byte framing, acknowledge, register pointer
`include "tsr_defs.svh"
module tsr_smb_slave (
  input  wire logic   link_clk_i,
  input  wire logic   reset_n_i,
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  output logic        sda_oe_o,
  tsr_link_if.serial  lnk
);
  typedef struct packed {
    tsr_pkg::tsr_ser_state_type state;
    tsr_pkg::tsr_phase_type     phase;
    logic                       scl_prev;
    logic                       sda_prev;
    logic [7:0]                 shift;
    logic [2:0]                 cnt;
    logic                       full;
    logic                       ack_it;
    logic                       rw;
    logic [7:0]                 ptr;
    logic                       sda_oe;
    logic                       req_tgl;
    tsr_pkg::tsr_op_type        op;
    logic [7:0]                 addr;
    logic [7:0]                 wdata;
    logic                       ack_seen;
    logic [7:0]                 rdata;
  } tsr_ser_reg_type;

  tsr_ser_reg_type r;
  tsr_ser_reg_type next_r;
  logic [2:0]      synced;
  logic            s_scl;
  logic            s_sda;
  logic            s_ack;
  logic            rise;
  logic            fall;
  logic [7:0]      rx_byte;

  // pins and the core's answer toggle are foreign to this clock
  tsr_sync #(.WIDTH(3)) u_sync (
    .clk_i     (link_clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({scl_i, sda_i, lnk.ack_tgl}),
    .q_o       (synced)
  );
  assign {s_scl, s_sda, s_ack} = synced;
  assign rise    = s_scl & ~r.scl_prev;
  assign fall    = ~s_scl & r.scl_prev;
  assign rx_byte = {r.shift[6:0], s_sda};

  always_comb begin
    next_r          = r;
    next_r.scl_prev = s_scl;
    next_r.sda_prev = s_sda;
    // rdata is stable once the answer toggle has been seen
    if (s_ack != r.ack_seen) begin
      next_r.ack_seen = s_ack;
      next_r.rdata    = lnk.rdata;
    end
    if (s_scl && r.scl_prev && r.sda_prev && !s_sda) begin
      // start or repeated start
      next_r.state  = tsr_pkg::TSR_SER_RECV;
      next_r.phase  = tsr_pkg::TSR_PH_ADDR;
      next_r.cnt    = 3'h0;
      next_r.full   = 1'b0;
      next_r.sda_oe = 1'b0;
    end else if (s_scl && r.scl_prev && !r.sda_prev && s_sda) begin
      next_r.state  = tsr_pkg::TSR_SER_IDLE;
      next_r.sda_oe = 1'b0;
    end else begin
      unique case (r.state)
        tsr_pkg::TSR_SER_IDLE: begin
          next_r.sda_oe = 1'b0;
        end
        tsr_pkg::TSR_SER_RECV: begin
          if (rise) begin
            next_r.shift = rx_byte;
            next_r.cnt   = r.cnt + 3'h1;
            if (r.cnt == 3'h7) begin
              next_r.full   = 1'b1;
              next_r.ack_it = 1'b1;
              unique case (r.phase)
                tsr_pkg::TSR_PH_ADDR: begin
                  // R8: one slave address for every register
                  next_r.ack_it = (rx_byte[7:1] == `TSR_SLAVE_ADDR);
                  next_r.rw     = rx_byte[0];
                  if ((rx_byte[7:1] == `TSR_SLAVE_ADDR) && rx_byte[0]) begin
                    // R10: receive byte returns the last selected register
                    next_r.req_tgl = ~r.req_tgl;
                    next_r.op      = tsr_pkg::TSR_OP_RD;
                    next_r.addr    = r.ptr;
                  end
                end
                tsr_pkg::TSR_PH_CMD: begin
                  // R21: command byte loads pointer
                  next_r.ptr     = rx_byte;
                  next_r.req_tgl = ~r.req_tgl;
                  next_r.op      = tsr_pkg::TSR_OP_SEL;
                  next_r.addr    = rx_byte;
                end
                tsr_pkg::TSR_PH_DATA: begin
                  next_r.req_tgl = ~r.req_tgl;
                  next_r.op      = tsr_pkg::TSR_OP_WR;
                  next_r.addr    = r.ptr;
                  next_r.wdata   = rx_byte;
                end
              endcase
            end
          end else if (fall && r.full) begin
            next_r.full   = 1'b0;
            next_r.sda_oe = r.ack_it;
            next_r.state  = r.ack_it ? tsr_pkg::TSR_SER_ACK_OUT : tsr_pkg::TSR_SER_IDLE;
          end
        end
        tsr_pkg::TSR_SER_ACK_OUT: begin
          if (fall) begin
            next_r.sda_oe = 1'b0;
            next_r.cnt    = 3'h0;
            next_r.state  = tsr_pkg::TSR_SER_RECV;
            unique case (r.phase)
              tsr_pkg::TSR_PH_ADDR: begin
                if (r.rw) begin
                  // R12: msb goes out first
                  next_r.state  = tsr_pkg::TSR_SER_SEND;
                  next_r.shift  = r.rdata;
                  next_r.sda_oe = ~r.rdata[7];
                end else begin
                  next_r.phase = tsr_pkg::TSR_PH_CMD;
                end
              end
              tsr_pkg::TSR_PH_CMD: begin
                next_r.phase = tsr_pkg::TSR_PH_DATA;
              end
              tsr_pkg::TSR_PH_DATA: begin
                // extra bytes of a write are not acknowledged
                next_r.state = tsr_pkg::TSR_SER_IDLE;
              end
            endcase
          end
        end
        tsr_pkg::TSR_SER_SEND: begin
          if (fall) begin
            next_r.cnt = r.cnt + 3'h1;
            if (r.cnt == 3'h7) begin
              next_r.sda_oe = 1'b0;
              next_r.state  = tsr_pkg::TSR_SER_ACK_IN;
            end else begin
              next_r.shift  = {r.shift[6:0], 1'b0};
              next_r.sda_oe = ~r.shift[6];
            end
          end
        end
        tsr_pkg::TSR_SER_ACK_IN: begin
          if (fall) begin
            next_r.state = tsr_pkg::TSR_SER_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r          <= '0;
      r.state    <= tsr_pkg::TSR_SER_IDLE;
      r.phase    <= tsr_pkg::TSR_PH_ADDR;
      r.op       <= tsr_pkg::TSR_OP_SEL;
      r.scl_prev <= 1'b1;
      r.sda_prev <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign sda_oe_o    = r.sda_oe;
  assign lnk.req_tgl = r.req_tgl;
  assign lnk.op      = r.op;
  assign lnk.addr    = r.addr;
  assign lnk.wdata   = r.wdata;
endmodule : tsr_smb_slave

// ---- verilog/tsr_readout.sv ----
// top of the sensor readout: register file, conversion control, standby handling
//
// Overview of operation
// R1: config halt bit at 1 enters software standby and stops conversions.
// R2: standby pin low enters hardware standby, converter disabled.
// R3: both standby forms keep registers and the serial slave alive.
// R4: one-shot in software standby starts one conversion sequence.
// R5: one-shot in hardware standby is ignored.
// R6: standby pin low overrides halt-bit clear and one-shot.
// R7: entering standby mid-conversion aborts it; old results stay readable.
// R8: all registers 8 bits, one slave address.
// R9: write byte, read byte, send byte and receive byte supported.
// R10: receive byte returns last selected register; host selects it first.
// R11: main local temperature at 00h, remote at 01h.
// R12: main result 8-bit two's complement, one degree per lsb, msb first.
// R13: at 4 Hz or slower fraction bits at 10h remote, 11h local.
// R14: main and fraction registers update together; host avoids split reads.
// R15: host may halt, one-shot, then read for coherent extended data.
// R16: busy reads 1 during a conversion, 0 after.
// R17: reset rate is 16 Hz, extended data invalid until slowed.
// R18: multi-master hosts should avoid the short transaction types.
// R19: halt bit at 0 gives free-running conversions at programmed rate.
// R20: each sequence measures local and remote, both results published.
// R21: send byte loads pointer; one-shot code starts a conversion.
`include "tsr_defs.svh"
module tsr_readout #(
  parameter int unsigned CONV_CYCLES = `TSR_CONV_CYCLES
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        link_clk_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        standby_pin_n_i,
  input  wire logic        adc_done_i,
  input  wire logic [10:0] adc_local_i,
  input  wire logic [10:0] adc_remote_i,
  output logic             adc_start_o,
  output logic             adc_abort_o,
  output logic             converter_enable_o,
  output logic             busy_o
);
  typedef struct packed {
    tsr_pkg::tsr_conv_state_type state;
    logic                        req_seen;
    logic                        ack_tgl;
    logic [7:0]                  rdata;
    logic [7:0]                  cfg;
    logic [7:0]                  rate;
    logic [7:0]                  local_main;
    logic [7:0]                  remote_main;
    logic [7:0]                  local_frac;
    logic [7:0]                  remote_frac;
    logic [31:0]                 timer;
    logic                        adc_start;
    logic                        adc_abort;
    logic                        conv_en;
    logic                        busy;
    logic                        one_shot_run;
  } tsr_core_reg_type;

  tsr_core_reg_type r;
  tsr_core_reg_type next_r;
  tsr_link_if       lnk ();
  logic [1:0]       synced;
  logic             s_req;
  logic             s_standby_n;
  logic             req_event;
  logic             hw_standby;
  logic             sw_standby;
  logic             one_shot;
  logic             ext_valid;

  // interval between automatic conversions, doubling per rate step below the fastest
  function automatic logic [31:0] conv_interval(input logic [7:0] rate);
    logic [7:0] clamped;
    clamped = (rate > `TSR_RATE_FASTEST) ? `TSR_RATE_FASTEST : rate;
    conv_interval = CONV_CYCLES[31:0] << (`TSR_RATE_FASTEST - clamped);
  endfunction : conv_interval

  function automatic logic [7:0] read_reg(input logic [7:0] addr, input tsr_core_reg_type s);
    unique case (addr)
      // R11: main results at fixed offsets
      `TSR_REG_LOCAL_MAIN:  read_reg = s.local_main;
      `TSR_REG_REMOTE_MAIN: read_reg = s.remote_main;
      // R16: busy flag in status
      `TSR_REG_STATUS:      read_reg = {s.busy, 7'h00};
      `TSR_REG_CFG_RD:      read_reg = s.cfg;
      `TSR_REG_RATE_RD:     read_reg = s.rate;
      // R13: fraction registers
      `TSR_REG_REMOTE_FRAC: read_reg = s.remote_frac;
      `TSR_REG_LOCAL_FRAC:  read_reg = s.local_frac;
      default:              read_reg = `TSR_UNMAPPED_READ;
    endcase
  endfunction : read_reg

  // R3: the serial engine runs on its own clock and never sees standby
  tsr_smb_slave u_slave (
    .link_clk_i (link_clk_i),
    .reset_n_i  (reset_n_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .sda_oe_o   (sda_oe_o),
    .lnk        (lnk)
  );

  tsr_sync #(.WIDTH(2)) u_sync (
    .clk_i     (core_clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({lnk.req_tgl, standby_pin_n_i}),
    .q_o       (synced)
  );
  assign {s_req, s_standby_n} = synced;

  assign req_event  = (s_req != r.req_seen);
  // R2: pin low is hardware standby
  assign hw_standby = ~s_standby_n;
  // R1: halt bit is software standby
  assign sw_standby = r.cfg[`TSR_CFG_HALT_BIT];
  // R21: the one-shot code counts whether it comes as a command or a write
  assign one_shot   = req_event && (lnk.addr == `TSR_REG_ONE_SHOT) &&
                      ((lnk.op == tsr_pkg::TSR_OP_SEL) || (lnk.op == tsr_pkg::TSR_OP_WR));
  // R17: fraction is only meaningful at 4 Hz or slower
  assign ext_valid  = (r.rate <= `TSR_RATE_EXT_MAX);

  always_comb begin
    next_r           = r;
    next_r.adc_start = 1'b0;
    next_r.adc_abort = 1'b0;

    // R9: one request per serial transaction step, answered by toggle
    if (req_event) begin
      next_r.req_seen = s_req;
      next_r.ack_tgl  = ~r.ack_tgl;
      unique case (lnk.op)
        tsr_pkg::TSR_OP_RD: begin
          // R10: reads follow the pointer held in the serial engine
          next_r.rdata = read_reg(lnk.addr, r);
        end
        tsr_pkg::TSR_OP_WR: begin
          if (lnk.addr == `TSR_REG_CFG_WR) begin
            next_r.cfg = lnk.wdata;
          end
          if (lnk.addr == `TSR_REG_RATE_WR) begin
            next_r.rate = lnk.wdata;
          end
        end
        tsr_pkg::TSR_OP_SEL: begin
        end
      endcase
    end

    if (r.timer != 32'h0) begin
      next_r.timer = r.timer - 32'h1;
    end

    unique case (r.state)
      tsr_pkg::TSR_CONV_IDLE: begin
        // R6: pin low blocks both software starts, halt-bit clear and one-shot
        if (!hw_standby) begin
          // R19: free running when not halted
          if (!sw_standby && r.timer == 32'h0) begin
            next_r.state     = tsr_pkg::TSR_CONV_RUN;
            next_r.adc_start = 1'b1;
            next_r.timer     = conv_interval(r.rate);
            next_r.one_shot_run = 1'b0;
          // R4: one-shot honoured in software standby and in run mode
          end else if (one_shot) begin
            next_r.one_shot_run = sw_standby;
            next_r.state     = tsr_pkg::TSR_CONV_RUN;
            next_r.adc_start = 1'b1;
          end
        end
        // R5: one-shot under hardware standby falls through unused
      end
      tsr_pkg::TSR_CONV_RUN: begin
        if (hw_standby || (sw_standby && !r.one_shot_run)) begin
          // R7: abort leaves the result registers untouched
          next_r.state     = tsr_pkg::TSR_CONV_IDLE;
          next_r.adc_abort = 1'b1;
        end else if (adc_done_i) begin
          // R14: main and fraction registers load in the same cycle
          // R20: both channels published together
          next_r.state       = tsr_pkg::TSR_CONV_IDLE;
          // R12: upper eight bits are the two's complement degrees
          next_r.local_main  = adc_local_i[10:3];
          next_r.remote_main = adc_remote_i[10:3];
          next_r.local_frac  = ext_valid ? {adc_local_i[2:0], 5'h00} : `TSR_TEMP_RESET;
          next_r.remote_frac = ext_valid ? {adc_remote_i[2:0], 5'h00} : `TSR_TEMP_RESET;
        end
      end
    endcase

    // R16: busy tracks the running sequence
    next_r.busy    = (next_r.state == tsr_pkg::TSR_CONV_RUN);
    // R1: converter held off in standby unless a one-shot is running
    next_r.conv_en = next_r.busy || !(hw_standby || sw_standby);
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r       <= '0;
      r.state <= tsr_pkg::TSR_CONV_IDLE;
      r.cfg   <= `TSR_CFG_RESET;
      // R17: power up at the fastest rate
      r.rate  <= `TSR_RATE_RESET;
    end else begin
      r <= next_r;
    end
  end

  // open-drain line: only ever pulled low, the enable carries the data
  assign sda_o              = 1'b0;
  assign lnk.ack_tgl        = r.ack_tgl;
  assign lnk.rdata          = r.rdata;
  assign adc_start_o        = r.adc_start;
  assign adc_abort_o        = r.adc_abort;
  assign converter_enable_o = r.conv_en;
  assign busy_o             = r.busy;
endmodule : tsr_readout

// ---- sim/tsr_readout_chk.sv ----
// concurrent checks on the ports of the sensor readout top
module tsr_readout_chk #(
  parameter int unsigned CONV_CYCLES = 200
) (
  input wire logic        core_clk_i,
  input wire logic        reset_n_i,
  input wire logic        link_clk_i,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire logic        standby_pin_n_i,
  input wire logic        adc_done_i,
  input wire logic [10:0] adc_local_i,
  input wire logic [10:0] adc_remote_i,
  input wire logic        adc_start_o,
  input wire logic        adc_abort_o,
  input wire logic        converter_enable_o,
  input wire logic        busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  property p_start_busy;
    @(posedge core_clk_i) disable iff (!reset_n_i) adc_start_o |=> busy_o;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy not raised after start");
  property p_busy_cause;
    @(posedge core_clk_i) disable iff (!reset_n_i) $rose(busy_o) |-> adc_start_o;
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy rose without start");
  property p_done_idle;
    @(posedge core_clk_i) disable iff (!reset_n_i) busy_o && adc_done_i |=> !busy_o;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("busy held after done");
  property p_start_idle;
    @(posedge core_clk_i) disable iff (!reset_n_i) adc_start_o |-> !$past(busy_o);
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("start while busy");
  property p_abort_drop;
    @(posedge core_clk_i) disable iff (!reset_n_i) adc_abort_o |-> !busy_o && $past(busy_o);
  endproperty
  a_abort_drop: assert property (p_abort_drop) else $error("abort without running sequence");
  // pin passes a two-flop synchroniser first, hence four samples
  property p_hw_no_start;
    @(posedge core_clk_i) disable iff (!reset_n_i) (!standby_pin_n_i) [*4] |-> !adc_start_o;
  endproperty
  a_hw_no_start: assert property (p_hw_no_start) else $error("start in hardware standby");
  property p_hw_power;
    @(posedge core_clk_i) disable iff (!reset_n_i) (!standby_pin_n_i) [*4] |-> !converter_enable_o;
  endproperty
  a_hw_power: assert property (p_hw_power) else $error("converter on in standby");
  property p_oe_scl_low;
    @(posedge link_clk_i) disable iff (!reset_n_i) $changed(sda_oe_o) |-> !scl_i;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data line moved while clock high");
  property p_open_drain;
    @(posedge link_clk_i) disable iff (!reset_n_i) sda_oe_o |-> (sda_o == 1'b0);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data line driven high");
endmodule : tsr_readout_chk

// ---- sim/tsr_host_model.sv ----
// smbus host master model for the readout's bus pins
`include "tsr_defs.svh"
module tsr_host_model (
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // low phase long enough for the slave's synchronised response
  localparam int TLO = 640;
  localparam int THI = 240;
  localparam logic [7:0] AW = {`TSR_SLAVE_ADDR, 1'b0};
  localparam logic [7:0] AR = {`TSR_SLAVE_ADDR, 1'b1};
  int nacks = 0;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // data only moves while the clock is low
  task automatic clk_bit(input logic drv, output logic smp);
    scl_o = 1'b0;
    #(TLO / 2) sda_low_o = !drv;
    #(TLO / 2) scl_o = 1'b1;
    #(THI / 2) smp = sda_i;
    #(THI / 2);
  endtask : clk_bit
  // start is (1,0), stop is (0,1): the data edge falls in the clock-high phase
  task automatic cond(input logic first, input logic last);
    scl_o = 1'b0;
    #(TLO / 2) sda_low_o = !first;
    #(TLO / 2) scl_o = 1'b1;
    #(THI) sda_low_o = !last;
    #(THI);
  endtask : cond
  task automatic put(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    if (s !== 1'b0) nacks++;
  endtask : put
  // kind 0 write byte, 1 read byte, 2 send byte, 3 receive byte
  task automatic xfer(input int kind, input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic s;
    rd = 8'h00;
    cond(1'b1, 1'b0);
    // receive relies on the pointer left by the last command
    if (kind != 3) begin
      put(AW);
      put(cmd);
    end
    if (kind == 0) put(wd);
    if (kind == 1) cond(1'b1, 1'b0);
    if (kind == 1 || kind == 3) begin
      put(AR);
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, rd[i]);
      clk_bit(1'b1, s);
    end
    cond(1'b0, 1'b1);
  endtask : xfer
endmodule : tsr_host_model

// ---- sim/testbench.sv ----
// testbench of the sensor readout: converter model, host model and scenarios
`include "tsr_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned CONV_CYCLES = 200;
  logic        core_clk, link_clk, reset_n, standby_pin_n, adc_done, conv_hold;
  logic [10:0] adc_local, adc_remote;
  logic        scl, host_low, sda_o, sda_oe, adc_start, adc_abort, conv_en, busy;
  wire         sda_line;
  int          mismatches, checked, starts, conv_cnt;
  logic [7:0]  d;
  assign sda_line = (sda_oe ? sda_o : 1'b1) && !host_low;
  tsr_readout #(.CONV_CYCLES(CONV_CYCLES)) u_tsr_readout (
    .core_clk_i(core_clk), .reset_n_i(reset_n), .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .standby_pin_n_i(standby_pin_n), .adc_done_i(adc_done),
    .adc_local_i(adc_local), .adc_remote_i(adc_remote), .adc_start_o(adc_start), .adc_abort_o(adc_abort),
    .converter_enable_o(conv_en), .busy_o(busy));
  tsr_host_model u_tsr_host_model (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda_line));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end
  // converter: answers five cycles after a start unless held, forgets an aborted run
  always @(posedge core_clk) begin
    #1;
    adc_done = 1'b0;
    if (adc_abort) conv_cnt = 0;
    else if (conv_cnt > 0) begin
      conv_cnt--;
      adc_done = (conv_cnt == 0);
    end
    if (adc_start) begin
      starts++;
      if (!conv_hold) conv_cnt = 5;
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask : chk1
  task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp, input string what);
    u_tsr_host_model.xfer(1, cmd, 8'h00, d);
    chk8(d, exp, what);
  endtask : rd_chk
  // sel 0 start pulse, 1 idle, 2 abort pulse
  task automatic wait_for(input int sel, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge core_clk);
      #1;
      if ((sel == 0 && adc_start) || (sel == 1 && busy === 1'b0) || (sel == 2 && adc_abort)) break;
    end
    if (n == lim) begin
      mismatches++;
      $display("[ERR] %0t wait %0d timed out", $time, sel);
      test_done();
    end
  endtask : wait_for
  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic test_reset();
    rd_chk(8'h04, `TSR_RATE_RESET, "rate after reset");
    u_tsr_host_model.xfer(3, 8'h00, 8'h00, d);
    chk8(d, `TSR_RATE_RESET, "receive byte pointer");
    $display("test reset done");
  endtask : test_reset
  task automatic test_run();
    rd_chk(8'h00, 8'hE7, "local main");
    u_tsr_host_model.xfer(0, 8'h0A, 8'h06, d);
    wait_for(0, 1200);
    wait_for(1, 50);
    rd_chk(8'h11, 8'hA0, "local fraction");
    rd_chk(8'h10, 8'h60, "remote fraction");
    $display("test run done");
  endtask : test_run
  task automatic test_soft_standby();
    int n;
    u_tsr_host_model.xfer(0, 8'h09, 8'h60, d);
    repeat (20) @(posedge core_clk);
    n = starts;
    repeat (1000) @(posedge core_clk);
    chk1(starts == n, 1'b1, "no start when halted");
    #1 adc_local = {8'h3C, 3'b001};
    adc_remote = {8'h7F, 3'b000};
    u_tsr_host_model.xfer(2, 8'h0F, 8'h00, d);
    repeat (10) @(posedge core_clk);
    chk1(starts == n + 1, 1'b1, "one-shot start");
    rd_chk(8'h01, 8'h7F, "remote after one-shot");
    chk1(starts == n + 1, 1'b1, "single sequence");
    $display("test soft standby done");
  endtask : test_soft_standby
  task automatic test_hw_standby();
    int n;
    @(posedge core_clk);
    #1 standby_pin_n = 1'b0;
    repeat (4) @(posedge core_clk);
    n = starts;
    chk1(conv_en, 1'b0, "converter off");
    u_tsr_host_model.xfer(2, 8'h0F, 8'h00, d);
    u_tsr_host_model.xfer(0, 8'h09, 8'h20, d);
    rd_chk(8'h03, 8'h20, "config in standby");
    chk1(conv_en, 1'b0, "pin over halt clear");
    chk1(starts == n, 1'b1, "no start in hw standby");
    $display("test hw standby done");
  endtask : test_hw_standby
  task automatic test_abort();
    conv_hold = 1'b1;
    @(posedge core_clk);
    #1 standby_pin_n = 1'b1;
    wait_for(0, 1200);
    adc_local = {8'h05, 3'b000};
    adc_remote = {8'h06, 3'b000};
    repeat (3) @(posedge core_clk);
    #1 standby_pin_n = 1'b0;
    wait_for(2, 8);
    chk1(busy, 1'b0, "busy after abort");
    conv_hold = 1'b0;
    rd_chk(8'h00, 8'h3C, "old local kept");
    $display("test abort done");
  endtask : test_abort
  initial begin
    mismatches = 0;
    checked = 0;
    starts = 0;
    conv_cnt = 0;
    reset_n = 1'b0;
    standby_pin_n = 1'b1;
    adc_done = 1'b0;
    conv_hold = 1'b0;
    adc_local = {8'hE7, 3'b101};
    adc_remote = {8'h19, 3'b011};
    // reset spans edges of the slow link clock as well
    repeat (8) @(posedge link_clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge link_clk);
    test_reset();
    test_run();
    test_soft_standby();
    test_hw_standby();
    test_abort();
    chk1(u_tsr_host_model.nacks == 0, 1'b1, "all bytes acknowledged");
    test_done();
  end
endmodule : testbench
bind tsr_readout tsr_readout_chk #(.CONV_CYCLES(CONV_CYCLES)) u_tsr_readout_chk (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .link_clk_i(link_clk_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .standby_pin_n_i(standby_pin_n_i), .adc_done_i(adc_done_i),
  .adc_local_i(adc_local_i), .adc_remote_i(adc_remote_i), .adc_start_o(adc_start_o),
  .adc_abort_o(adc_abort_o), .converter_enable_o(converter_enable_o), .busy_o(busy_o));
